//--- ittc_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the register file
// Assumes: One write and one read outstanding at most
// Notes:   Unmapped or misaligned addresses answer SLVERR
`timescale 1ns/1ps
`default_nettype none
module ittc_axil_slave
  import ittc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  ittc_regbus_if.bus             rb
);
  typedef struct packed {
    logic        aw_h;
    logic [5:0]  aw_a;
    logic        w_h;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ittc_axi_s;

  ittc_axi_s r, n;

  assign s_axi_awready = !r.aw_h && !r.bvalid;
  assign s_axi_wready  = !r.w_h && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign rb.wr_addr    = r.aw_a;
  assign rb.wr_data    = r.w_d;
  assign rb.wr_strb    = r.w_s;
  assign rb.rd_addr    = s_axi_araddr;

  always_comb begin
    n        = r;
    rb.wr_en = 1'b0;
    rb.rd_en = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_h = 1'b1;
      n.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_h = 1'b1;
      n.w_d = s_axi_wdata;
      n.w_s = s_axi_wstrb;
    end
    // Commit only once both halves are held, response a cycle later
    if (r.aw_h && r.w_h) begin
      rb.wr_en = 1'b1;
      n.aw_h   = 1'b0;
      n.w_h    = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = rb.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rb.rd_en = 1'b1;
      n.rvalid = 1'b1;
      n.rdata  = rb.rd_ok ? rb.rd_data : 32'h0000_0000;
      n.rresp  = rb.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // ittc_axil_slave
`default_nettype wire

//--- ittc_core.sv
// Purpose: I2C target transfer engine with AXI4-Lite registers
// Assumes: aclk at least eight times the SCL rate during transfers
// Notes:   Bus lines are open drain, oe high pulls the line low
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Module enable arms start detection
// - Own address matched gets ACK, direction followed
// - Comm disabled: own address gets NAK
// - Busy, addressed, direction tracked per frame
// - Async detect hit: flag, NAK, write-one clear
// - Transmit empty sets on load, clears on write
// - Transmit data discarded while async detect on
// - Stale byte sent; clear bit empties buffer
// - Missing byte resends old data, flags underflow
// - Stretching holds SCL until write or read
// - Bits out MSB first, ninth clock samples ACK
// - Master NAK flagged, no stretch after NAK
// - Driven bit compared with line, mismatch flagged
// - Receive eight bits, load, set receive ready
// - Unread byte overwritten sets overflow flag
// - NAK reply bit chooses byte answer
// - Stop when addressed: flag, release, reinitialise
// - Stretching only when its enable is set
// - Any status flag sets summary bit
module ittc_core
  import ittc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              serial_clock_pin_i,
  output logic                   serial_clock_pin_o,
  output logic                   serial_clock_pin_oe,
  input  wire logic              serial_data_pin_i,
  output logic                   serial_data_pin_o,
  output logic                   serial_data_pin_oe
);
  typedef struct packed {
    ittc_state_e       state;
    logic [CTRL_W-1:0] ctl;
    logic [6:0]        own;
    logic [7:0]        tx_buf;
    logic              tx_full;
    logic              tx_empty;
    logic [7:0]        rx_data;
    logic              rx_ready;
    logic [FLAG_W-1:0] flags;
    logic [7:0]        shreg;
    logic [3:0]        cnt;
    logic              busy;
    logic              addressed;
    logic              dir;
    logic              sda_oe;
    logic              scl_oe;
    logic              scl_q;
    logic              sda_q;
  } ittc_core_s;

  ittc_core_s    r, n;
  ittc_regbus_if rb ();
  logic [1:0]    pins_s;
  logic          scl_s, sda_s;
  logic          start_c, stop_c, rise_c, fall_c;
  logic          go_tx, load_c, rxload_c, txwr_c, summary;

  ittc_axil_slave u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rb            (rb)
  );

  ittc_pin_sync #(.W(2)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({serial_clock_pin_i, serial_data_pin_i}),
    .q       (pins_s)
  );

  assign scl_s   = pins_s[1];
  assign sda_s   = pins_s[0];
  assign start_c = r.scl_q && scl_s && r.sda_q && !sda_s;
  assign stop_c  = r.scl_q && scl_s && !r.sda_q && sda_s;
  assign rise_c  = !r.scl_q && scl_s;
  assign fall_c  = r.scl_q && !scl_s;
  assign summary = |r.flags;
  assign txwr_c  = rb.wr_en && rb.wr_ok && rb.wr_strb[0] && (rb.wr_addr == OFS_TXD);

  assign serial_clock_pin_o  = 1'b0;
  assign serial_data_pin_o   = 1'b0;
  assign serial_clock_pin_oe = r.scl_oe;
  assign serial_data_pin_oe  = r.sda_oe;

  assign rb.wr_ok = ittc_mapped(rb.wr_addr);
  assign rb.rd_ok = ittc_mapped(rb.rd_addr);

  always_comb begin
    case (rb.rd_addr)
      OFS_CTRL:  rb.rd_data = {26'h0, r.ctl};
      OFS_ADDR:  rb.rd_data = {25'h0, r.own};
      OFS_TXD:   rb.rd_data = {24'h0, r.tx_buf};
      OFS_RXD:   rb.rd_data = {24'h0, r.rx_data};
      OFS_STAT:  rb.rd_data = {24'h0, summary, 1'b0, r.flags};
      OFS_ASTAT: rb.rd_data = {27'h0, r.rx_ready, r.tx_empty, r.dir, r.addressed, r.busy};
      default:   rb.rd_data = 32'h0000_0000;
    endcase
  end

  always_comb begin
    n        = r;
    go_tx    = 1'b0;
    load_c   = 1'b0;
    rxload_c = 1'b0;
    n.scl_q  = scl_s;
    n.sda_q  = sda_s;
    if (rb.wr_en && rb.wr_ok && rb.wr_strb[0]) begin
      case (rb.wr_addr)
        OFS_CTRL: n.ctl = rb.wr_data[CTRL_W-1:0];
        OFS_ADDR: n.own = rb.wr_data[6:0];
        OFS_TXD: begin
          // Data written during async detection is discarded
          if (!r.ctl[CB_ASYNC_EN]) begin
            n.tx_buf  = rb.wr_data[7:0];
            n.tx_full = 1'b1;
          end
          n.tx_empty = 1'b0;
        end
        OFS_STAT: n.flags = r.flags & ~rb.wr_data[FLAG_W-1:0];
        default: ;
      endcase
    end
    if (rb.rd_en && rb.rd_ok && rb.rd_addr == OFS_RXD) begin
      n.rx_ready = 1'b0;
    end
    if (r.ctl[CB_TX_CLR]) begin
      n.tx_buf  = RST_DATA;
      n.tx_full = 1'b0;
    end
    if (!r.ctl[CB_MOD_EN]) begin
      n.state     = ST_OFF;
      n.busy      = 1'b0;
      n.addressed = 1'b0;
      n.sda_oe    = 1'b0;
    end else if (stop_c) begin
      if (r.addressed) begin
        n.flags[SB_STOP] = 1'b1;
      end
      n.busy      = 1'b0;
      n.addressed = 1'b0;
      n.sda_oe    = 1'b0;
      n.state     = ST_IDLE;
    end else if (start_c) begin
      // Repeated start ends the current selection too
      if (r.addressed) begin
        n.flags[SB_STOP] = 1'b1;
      end
      n.busy      = 1'b1;
      n.addressed = 1'b0;
      n.sda_oe    = 1'b0;
      n.cnt       = 4'h0;
      n.state     = ST_ADDR;
    end else begin
      case (r.state)
        ST_OFF: n.state = ST_IDLE;
        ST_IDLE, ST_SKIP: ;
        ST_ADDR: begin
          if (rise_c) begin
            n.shreg = {r.shreg[6:0], sda_s};
            n.cnt   = r.cnt + 4'h1;
          end else if (fall_c && r.cnt == BITS_PER_BYTE) begin
            n.cnt   = 4'h0;
            n.state = ST_SKIP;
            if (r.shreg[7:1] == r.own) begin
              if (r.ctl[CB_ASYNC_EN]) begin
                n.flags[SB_ASYNC] = 1'b1;
              end else if (r.ctl[CB_COMM_EN]) begin
                n.addressed = 1'b1;
                n.dir       = r.shreg[0];
                n.sda_oe    = 1'b1;
                n.state     = ST_AACK;
              end
            end
          end
        end
        ST_AACK: begin
          if (fall_c) begin
            n.sda_oe = 1'b0;
            if (r.dir) begin
              go_tx = 1'b1;
            end else begin
              n.state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (rise_c) begin
            if (sda_s != r.shreg[7]) begin
              n.flags[SB_MISMATCH] = 1'b1;
            end
            n.cnt = r.cnt + 4'h1;
          end else if (fall_c) begin
            if (r.cnt == BITS_PER_BYTE) begin
              n.sda_oe = 1'b0;
              n.state  = ST_TACK;
            end else begin
              n.shreg  = {r.shreg[6:0], 1'b0};
              n.sda_oe = !r.shreg[6];
            end
          end
        end
        ST_TACK: begin
          if (rise_c && sda_s) begin
            n.flags[SB_MNAK] = 1'b1;
            n.state          = ST_SKIP;
          end else if (fall_c) begin
            go_tx = 1'b1;
          end
        end
        ST_TSTALL: go_tx = 1'b1;
        ST_RX: begin
          if (rise_c) begin
            n.shreg = {r.shreg[6:0], sda_s};
            n.cnt   = r.cnt + 4'h1;
          end else if (fall_c && r.cnt == BITS_PER_BYTE) begin
            rxload_c = 1'b1;
            n.rx_data  = r.shreg;
            n.rx_ready = 1'b1;
            if (n.rx_ready && r.rx_ready) begin
              n.flags[SB_OVF] = 1'b1;
            end
            n.sda_oe = !r.ctl[CB_NAK_REPLY];
            n.cnt    = 4'h0;
            n.state  = r.ctl[CB_STRETCH] ? ST_RSTALL : ST_RACK;
          end
        end
        ST_RSTALL: begin
          if (!r.rx_ready || !r.ctl[CB_STRETCH]) begin
            n.state = ST_RACK;
          end
        end
        ST_RACK: begin
          if (fall_c) begin
            n.sda_oe = 1'b0;
            n.state  = ST_RX;
          end
        end
        default: n.state = ST_IDLE;
      endcase
    end
    if (go_tx) begin
      // A write in this very cycle is taken by the load
      if (n.tx_full || !r.ctl[CB_STRETCH]) begin
        load_c     = 1'b1;
        n.shreg    = n.tx_buf;
        n.sda_oe   = !n.tx_buf[7];
        n.tx_empty = 1'b1;
        n.tx_full  = 1'b0;
        n.cnt   = 4'h0;
        n.state = ST_TX;
      end else begin
        n.state = ST_TSTALL;
      end
    end
    if (!n.tx_full && load_c && !r.tx_full && !txwr_c) begin
      n.flags[SB_UDF] = 1'b1;
    end
    n.scl_oe = (n.state == ST_TSTALL) || (n.state == ST_RSTALL);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r         <= '0;
      r.ctl     <= RST_CTRL;
      r.own     <= RST_OWN_ADDR;
      r.tx_buf  <= RST_DATA;
      r.rx_data <= RST_DATA;
      r.scl_q   <= 1'b1;
      r.sda_q   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  chk_busy_on_start: assert property (@(posedge aclk) disable iff (!aresetn)
    r.ctl[CB_MOD_EN] && start_c |=> r.busy) else $error("busy not set on start");
  chk_stop_release: assert property (@(posedge aclk) disable iff (!aresetn)
    r.ctl[CB_MOD_EN] && stop_c && r.addressed |=> r.flags[SB_STOP] && !r.busy
    && !r.addressed && !r.sda_oe && !r.scl_oe) else $error("stop not handled");
  chk_addr_needs_comm: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(r.addressed) |-> $past(r.ctl[CB_COMM_EN]) && !$past(r.ctl[CB_ASYNC_EN])
    && r.sda_oe) else $error("address answered while disabled");
  chk_async_nak: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(r.flags[SB_ASYNC]) |-> !r.sda_oe && !r.addressed && summary)
    else $error("async hit not answered with NAK");
  chk_txe_write: assert property (@(posedge aclk) disable iff (!aresetn)
    txwr_c && !load_c |=> !r.tx_empty) else $error("tx empty not cleared");
  chk_rx_overflow: assert property (@(posedge aclk) disable iff (!aresetn)
    rxload_c && r.rx_ready |=> r.flags[SB_OVF] && r.rx_ready)
    else $error("overflow not flagged");
  chk_nak_reply: assert property (@(posedge aclk) disable iff (!aresetn)
    rxload_c |=> r.sda_oe == !$past(r.ctl[CB_NAK_REPLY]))
    else $error("wrong byte answer");
  chk_no_stretch: assert property (@(posedge aclk) disable iff (!aresetn)
    !r.ctl[CB_STRETCH] && !$past(r.ctl[CB_STRETCH]) |-> !r.scl_oe)
    else $error("stretch while disabled");
  chk_load_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    load_c |=> r.tx_empty && r.sda_oe == !r.shreg[7] && r.cnt == 4'h0)
    else $error("load did not drive MSB");
  chk_rx_read: assert property (@(posedge aclk) disable iff (!aresetn)
    rb.rd_en && rb.rd_addr == OFS_RXD && !rxload_c |=> !r.rx_ready)
    else $error("read did not clear rx ready");
endmodule // ittc_core
`default_nettype wire

//--- ittc_ctrl_model.sv
// Purpose: Behavioural I2C bus controller that drives SCL
// Assumes: Both lines pulled up, oe high pulls a line low
// Notes:   SCL period is eight aclk cycles, high for four
`timescale 1ns/1ps
`default_nettype none
module ittc_ctrl_model (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  initial begin
    scl_oe = 1'h0;
    sda_oe = 1'h0;
  end
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  // Target may stretch; only the bench timeout ends this
  task automatic wait_hi();
    do @(negedge clk); while (scl !== 1'h1);
  endtask
  task automatic start();
    @(posedge clk);
    sda_oe <= 1'h0;
    half();
    scl_oe <= 1'h0;
    wait_hi();
    half();
    sda_oe <= 1'h1;
    half();
    scl_oe <= 1'h1;
  endtask
  // Data changes one cycle after SCL falls, never with it
  task automatic bit_io(input logic b, output logic s);
    @(posedge clk);
    sda_oe <= ~b;
    // Low phase short by the data cycle, keeps the period at eight
    repeat (3) @(posedge clk);
    scl_oe <= 1'h0;
    wait_hi();
    half();
    s = sda;
    scl_oe <= 1'h1;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                      output logic a_out);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a_in, a_out);
  endtask
  task automatic stop();
    @(posedge clk);
    sda_oe <= 1'h1;
    half();
    scl_oe <= 1'h0;
    wait_hi();
    half();
    sda_oe <= 1'h0;
    half();
  endtask
endmodule // ittc_ctrl_model
`default_nettype wire

//--- ittc_pin_sync.sv
// Purpose: Two-stage synchroniser for bus line inputs
// Assumes: Inputs asynchronous to aclk
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module ittc_pin_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ittc_sync_s;

  ittc_sync_s r, n;

  always_comb begin
    n    = r;
    n.s1 = d;
    n.s2 = r.s1;
  end

  assign q = r.s2;

  // Idle bus lines are high, so reset to high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '1;
    end else begin
      r <= n;
    end
  end
endmodule // ittc_pin_sync
`default_nettype wire

//--- ittc_pkg.sv
// Purpose: Shared constants and types of the I2C target transfer engine
// Assumes: 32-bit AXI4-Lite register bus, word aligned registers
// Notes:   Offsets are byte addresses
package ittc_pkg;
  localparam int unsigned ADDR_W        = 6;
  localparam int unsigned CTRL_W        = 6;
  localparam int unsigned FLAG_W        = 6;
  localparam logic [5:0]  OFS_CTRL      = 6'h00;
  localparam logic [5:0]  OFS_ADDR      = 6'h04;
  localparam logic [5:0]  OFS_TXD       = 6'h08;
  localparam logic [5:0]  OFS_RXD       = 6'h0C;
  localparam logic [5:0]  OFS_STAT      = 6'h10;
  localparam logic [5:0]  OFS_ASTAT     = 6'h14;
  // control_register fields
  localparam int unsigned CB_MOD_EN     = 0;
  localparam int unsigned CB_COMM_EN    = 1;
  localparam int unsigned CB_STRETCH    = 2;
  localparam int unsigned CB_ASYNC_EN   = 3;
  localparam int unsigned CB_NAK_REPLY  = 4;
  localparam int unsigned CB_TX_CLR     = 5;
  // bus_status_register fields
  localparam int unsigned SB_ASYNC      = 0;
  localparam int unsigned SB_UDF        = 1;
  localparam int unsigned SB_MNAK       = 2;
  localparam int unsigned SB_MISMATCH   = 3;
  localparam int unsigned SB_OVF        = 4;
  localparam int unsigned SB_STOP       = 5;
  localparam logic [5:0]  RST_CTRL      = 6'h00;
  localparam logic [6:0]  RST_OWN_ADDR  = 7'h00;
  localparam logic [7:0]  RST_DATA      = 8'h00;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [3:0] {
    ST_OFF, ST_IDLE, ST_ADDR, ST_AACK, ST_TX, ST_TACK, ST_TSTALL,
    ST_RX, ST_RSTALL, ST_RACK, ST_SKIP
  } ittc_state_e;

  function automatic logic ittc_mapped(input logic [5:0] a);
    return (a == OFS_CTRL) || (a == OFS_ADDR) || (a == OFS_TXD) ||
           (a == OFS_RXD) || (a == OFS_STAT) || (a == OFS_ASTAT);
  endfunction
endpackage

//--- ittc_regbus_if.sv
// Purpose: Register access carrier between bus slave and core
// Assumes: Single clock, rd_data combinational from rd_addr
// Notes:   wr_en and rd_en are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface ittc_regbus_if;
  logic        wr_en;
  logic [5:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic        rd_en;
  logic [5:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

//--- tb_i2c_target_transfer_control.sv
// Purpose: Self-checking bench of the I2C target engine
// Assumes: Controller model makes SCL at a 200 ns period
// Notes:   Scenarios run in order after one reset
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_target_transfer_control import ittc_pkg::*; ();
  localparam logic [7:0] ADR_W = 8'h54;
  localparam logic [7:0] ADR_R = 8'h55;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        scl_oe, sda_oe, m_scl_oe, m_sda_oe, scl, sda;
  int          n_mismatch = 0, n_checks = 0, cyc = 0;
  assign scl = ~(scl_oe | m_scl_oe);
  assign sda = ~(sda_oe | m_sda_oe);
  always #12.5 aclk = ~aclk;
  ittc_core i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clock_pin_i(scl), .serial_clock_pin_o(), .serial_clock_pin_oe(scl_oe),
    .serial_data_pin_i(sda), .serial_data_pin_o(), .serial_data_pin_oe(sda_oe));
  ittc_ctrl_model i_ctl (.clk(aclk), .scl(scl), .sda(sda), .scl_oe(m_scl_oe),
    .sda_oe(m_sda_oe));
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_line(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [5:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (tb !== 1'h1);
    bready <= 1'h0;
    chk_word({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic axr(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
    end while (tr !== 1'h1);
    rready <= 1'h0;
    chk_word(d, ed);
    chk_word({30'h0, r}, {30'h0, er});
  endtask
  task automatic send(input logic [7:0] d, input logic ea);
    logic [7:0] q;
    logic a;
    i_ctl.xfer(d, 1'h1, q, a);
    chk_line(a, ea);
  endtask
  task automatic recv(input logic ma, input logic [7:0] md, input logic [7:0] eq);
    logic [7:0] q;
    logic a;
    i_ctl.xfer(md, ma, q, a);
    chk_word({24'h0, q}, {24'h0, eq});
  endtask
  task automatic t_comm_off();
    axw(OFS_CTRL, 32'h1);
    i_ctl.start();
    send(ADR_W, 1'h1);
    axr(OFS_ASTAT, 32'h1, RESP_OKAY);
    i_ctl.stop();
    axr(OFS_STAT, 32'h0, RESP_OKAY);
  endtask
  // Receive: read, then overflow on the byte given a NAK reply
  task automatic t_rx();
    axw(OFS_CTRL, 32'h3);
    i_ctl.start();
    send(ADR_W, 1'h0);
    axr(OFS_ASTAT, 32'h3, RESP_OKAY);
    send(8'hC1, 1'h0);
    axr(OFS_ASTAT, 32'h13, RESP_OKAY);
    axr(OFS_RXD, 32'hC1, RESP_OKAY);
    send(8'h3C, 1'h0);
    axw(OFS_CTRL, 32'h13);
    send(8'h6E, 1'h1);
    axr(OFS_RXD, 32'h6E, RESP_OKAY);
    axr(OFS_ASTAT, 32'h3, RESP_OKAY);
    i_ctl.stop();
    axr(OFS_STAT, 32'hB0, RESP_OKAY);
    axr(OFS_ASTAT, 32'h0, RESP_OKAY);
    axw(OFS_STAT, 32'h3F);
    axr(OFS_STAT, 32'h0, RESP_OKAY);
  endtask
  // Transmit without stretch: stale resend, clash, master NAK
  task automatic t_tx();
    axw(OFS_CTRL, 32'h3);
    axw(OFS_TXD, 32'hC5);
    i_ctl.start();
    send(ADR_R, 1'h0);
    // Load follows the ninth fall after two sync stages
    repeat (3) @(posedge aclk);
    axr(OFS_ASTAT, 32'hF, RESP_OKAY);
    @(negedge aclk);
    chk_line(scl_oe, 1'h0);
    recv(1'h0, 8'hFF, 8'hC5);
    recv(1'h1, 8'hFE, 8'hC4);
    i_ctl.stop();
    axr(OFS_STAT, 32'hAE, RESP_OKAY);
    axw(OFS_STAT, 32'h3F);
  endtask
  task automatic t_stretch();
    axw(OFS_TXD, 32'h77);
    axw(OFS_CTRL, 32'h27);
    axw(OFS_CTRL, 32'h7);
    axr(OFS_TXD, 32'h0, RESP_OKAY);
    i_ctl.start();
    send(ADR_R, 1'h0);
    repeat (40) @(negedge aclk);
    chk_line(scl_oe, 1'h1);
    axw(OFS_TXD, 32'h4B);
    recv(1'h0, 8'hFF, 8'h4B);
    repeat (40) @(negedge aclk);
    chk_line(scl_oe, 1'h1);
    axw(OFS_TXD, 32'h96);
    recv(1'h1, 8'hFF, 8'h96);
    repeat (40) @(negedge aclk);
    chk_line(scl_oe, 1'h0);
    i_ctl.stop();
    axr(OFS_STAT, 32'hA4, RESP_OKAY);
    axw(OFS_STAT, 32'h3F);
  endtask
  task automatic t_async();
    axw(OFS_CTRL, 32'hB);
    axw(OFS_TXD, 32'h5A);
    axr(OFS_TXD, 32'h96, RESP_OKAY);
    i_ctl.start();
    send(ADR_W, 1'h1);
    i_ctl.stop();
    axr(OFS_STAT, 32'h81, RESP_OKAY);
    axw(OFS_STAT, 32'h1);
    axr(OFS_STAT, 32'h0, RESP_OKAY);
    axr(OFS_ASTAT, 32'h4, RESP_OKAY);
    axw(OFS_CTRL, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    axr(OFS_CTRL, 32'h0, RESP_OKAY);
    axr(OFS_STAT, 32'h0, RESP_OKAY);
    axr(6'h18, 32'h0, RESP_SLVERR);
    axw(OFS_ADDR, 32'h2A);
    axr(OFS_ADDR, 32'h2A, RESP_OKAY);
    t_comm_off();
    t_rx();
    t_tx();
    t_stretch();
    t_async();
    end_of_test();
  end
endmodule // tb_i2c_target_transfer_control
`default_nettype wire
